// ### logic/can_spi_decoder.sv
`timescale 1ns/1ps

module can_spi_decoder
  import can_spi_pkg::*;
(
  input  wire logic REF_CLK,
  input  wire logic RST_N,
  input  wire logic CE,
  input  wire logic SCK,
  input  wire logic CS_N,
  input  wire logic SI,
  output logic      SO_OUT,
  output logic      SO_OE
);

  typedef enum logic [7:0] {
    ST_OPCODE = 8'b0000_0001,
    ST_ADDR   = 8'b0000_0010,
    ST_RDATA  = 8'b0000_0100,
    ST_WDATA  = 8'b0000_1000,
    ST_MASK   = 8'b0001_0000,
    ST_MDATA  = 8'b0010_0000,
    ST_STAT   = 8'b0100_0000,
    ST_IGNORE = 8'b1000_0000
  } state_type;

  typedef enum logic [2:0] {
    K_READ   = 3'b001,
    K_WRITE  = 3'b010,
    K_MODIFY = 3'b100
  } kind_type;

  function automatic logic [7:0] reg_default(input int idx);
    logic [IDX_W-1:0] a;
    a = IDX_W'(idx);
    if (a[3:0] == STAT_LOW_ADR) return STAT_DEFAULT;
    if (a[3:0] == CTRL_LOW_ADR) return CTRL_DEFAULT;
    return 8'h00;
  endfunction : reg_default

  // ---------------------------------------------------------------
  // Link side, SCK domain; frame end clears all but the handshake word
  // ---------------------------------------------------------------
  logic       link_rst_n;
  logic [2:0] bit_cnt_reg,  bit_cnt_next;
  logic [7:0] rx_shift_reg, rx_shift_next;
  logic [7:0] rx_hold_reg,  rx_hold_next;
  logic       rx_tgl_reg,   rx_tgl_next;
  logic [7:0] tx_shift_reg, tx_shift_next;
  logic       so_oe_reg,    so_oe_next;
  logic [7:0] tx_byte_reg,  tx_byte_next;
  logic       drive_reg,    drive_next;

  assign link_rst_n = RST_N & ~CS_N;

  always_comb begin
    bit_cnt_next  = bit_cnt_reg + 3'h1;
    rx_shift_next = {rx_shift_reg[6:0], SI};
    rx_hold_next  = rx_hold_reg;
    rx_tgl_next   = rx_tgl_reg;
    if (bit_cnt_reg == BIT_LAST) begin
      rx_hold_next = {rx_shift_reg[6:0], SI};
      rx_tgl_next  = ~rx_tgl_reg;
    end
  end

  always_ff @(posedge SCK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt_reg  <= 3'h0;
      rx_shift_reg <= 8'h00;
    end else begin
      bit_cnt_reg  <= bit_cnt_next;
      rx_shift_reg <= rx_shift_next;
    end
  end

  // Handshake word survives CS_N rising: clearing the toggle there
  // would fake a byte event after every odd-length frame.
  always_ff @(posedge SCK or negedge RST_N) begin
    if (!RST_N) begin
      rx_hold_reg <= 8'h00;
      rx_tgl_reg  <= 1'b0;
    end else begin
      rx_hold_reg <= rx_hold_next;
      rx_tgl_reg  <= rx_tgl_next;
    end
  end

  // Core word is settled well before this edge: half a bit time
  // after the toggle, and held until the next byte event.
  // drive falling
  always_comb begin
    tx_shift_next = {tx_shift_reg[6:0], 1'b0};
    so_oe_next    = so_oe_reg;
    if (bit_cnt_reg == 3'h0) begin
      tx_shift_next = tx_byte_reg;
      so_oe_next    = drive_reg;
    end
  end

  always_ff @(negedge SCK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      tx_shift_reg <= 8'h00;
      so_oe_reg    <= 1'b0;
    end else begin
      tx_shift_reg <= tx_shift_next;
      so_oe_reg    <= so_oe_next;
    end
  end

  assign SO_OUT = tx_shift_reg[7];
  assign SO_OE  = so_oe_reg;

  // ---------------------------------------------------------------
  // Crossing into REF_CLK
  // ---------------------------------------------------------------
  logic [2:0] tgl_sync_reg, tgl_sync_next;
  logic [1:0] cs_sync_reg,  cs_sync_next;
  logic       byte_evt;
  logic       frame_idle;

  always_comb begin
    tgl_sync_next = {tgl_sync_reg[1:0], rx_tgl_reg};
    cs_sync_next  = {cs_sync_reg[0], CS_N};
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tgl_sync_reg <= 3'h0;
      cs_sync_reg  <= 2'h3;
    end else if (CE) begin
      tgl_sync_reg <= tgl_sync_next;
      cs_sync_reg  <= cs_sync_next;
    end
  end

  assign byte_evt   = CE & (tgl_sync_reg[2] ^ tgl_sync_reg[1]);
  assign frame_idle = cs_sync_reg[1];

  // ---------------------------------------------------------------
  // Command engine and register array
  // ---------------------------------------------------------------
  state_type      state_reg, state_next;
  kind_type       kind_reg,  kind_next;
  logic [7:0]     ptr_reg,   ptr_next;
  logic [7:0]     mask_reg,  mask_next;
  logic [7:0]     mem_reg  [REG_COUNT];
  logic [7:0]     mem_next [REG_COUNT];
  logic [7:0]     rx_byte;
  logic [7:0]     status_byte;
  logic [IDX_W-1:0] idx;

  assign rx_byte = rx_hold_reg;
  assign idx     = ptr_reg[IDX_W-1:0];

  assign status_byte = {mem_reg[INTF_ADR][TX2IF_BIT], mem_reg[TXB2_ADR][REQ_FLAG_BIT],
                        mem_reg[INTF_ADR][TX1IF_BIT], mem_reg[TXB1_ADR][REQ_FLAG_BIT],
                        mem_reg[INTF_ADR][TX0IF_BIT], mem_reg[TXB0_ADR][REQ_FLAG_BIT],
                        mem_reg[INTF_ADR][RX1IF_BIT], mem_reg[INTF_ADR][RX0IF_BIT]};

  always_comb begin
    state_next   = state_reg;
    kind_next    = kind_reg;
    ptr_next     = ptr_reg;
    mask_next    = mask_reg;
    tx_byte_next = tx_byte_reg;
    drive_next   = drive_reg;
    mem_next     = mem_reg;
    if (byte_evt) begin
      unique case (state_reg)
        ST_OPCODE: begin
          state_next = ST_IGNORE;
          if (rx_byte == OP_READ) begin
            state_next = ST_ADDR;
            kind_next  = K_READ;
          end else if (rx_byte == OP_WRITE) begin
            state_next = ST_ADDR;
            kind_next  = K_WRITE;
          end else if (rx_byte == OP_MODIFY) begin
            state_next = ST_ADDR;
            kind_next  = K_MODIFY;
          end else if (rx_byte == OP_STATUS) begin
            state_next   = ST_STAT;
            tx_byte_next = status_byte;
            drive_next   = 1'b1;
          end else if (rx_byte[7:3] == OP_RTS_TOP) begin
            if (rx_byte[0]) mem_next[TXB0_ADR][REQ_FLAG_BIT] = 1'b1;
            if (rx_byte[1]) mem_next[TXB1_ADR][REQ_FLAG_BIT] = 1'b1;
            if (rx_byte[2]) mem_next[TXB2_ADR][REQ_FLAG_BIT] = 1'b1;
          end else if (rx_byte == OP_RESET) begin
            for (int i = 0; i < REG_COUNT; i++) mem_next[i] = reg_default(i);
          end
        end
        ST_ADDR: begin
          ptr_next = rx_byte;
          unique case (kind_reg)
            K_READ: begin
              state_next   = ST_RDATA;
              tx_byte_next = mem_reg[rx_byte[IDX_W-1:0]];
              drive_next   = 1'b1;
              ptr_next     = rx_byte + 8'h01;
            end
            K_WRITE:  state_next = ST_WDATA;
            K_MODIFY: state_next = ST_MASK;
          endcase
        end
        ST_RDATA: begin
          tx_byte_next = mem_reg[idx];
          ptr_next     = ptr_reg + 8'h01;
        end
        ST_WDATA: begin
          mem_next[idx] = rx_byte;
          ptr_next      = ptr_reg + 8'h01;
        end
        ST_MASK: begin
          mask_next  = rx_byte;
          state_next = ST_MDATA;
        end
        ST_MDATA: begin
          mem_next[idx] = (mem_reg[idx] & ~mask_reg) | (rx_byte & mask_reg);
          state_next    = ST_IGNORE;
        end
        ST_STAT: tx_byte_next = status_byte;
        ST_IGNORE: drive_next = 1'b0;
      endcase
    end else if (frame_idle) begin
      state_next = ST_OPCODE;
      drive_next = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg   <= ST_OPCODE;
      kind_reg    <= K_READ;
      ptr_reg     <= 8'h00;
      mask_reg    <= 8'h00;
      tx_byte_reg <= 8'h00;
      drive_reg   <= 1'b0;
      for (int i = 0; i < REG_COUNT; i++) mem_reg[i] <= reg_default(i);
    end else if (CE) begin
      state_reg   <= state_next;
      kind_reg    <= kind_next;
      ptr_reg     <= ptr_next;
      mask_reg    <= mask_next;
      tx_byte_reg <= tx_byte_next;
      drive_reg   <= drive_next;
      mem_reg     <= mem_next;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_read_op;
    @(posedge REF_CLK) disable iff (!RST_N)
    byte_evt && state_reg == ST_OPCODE && rx_byte == OP_READ |=> state_reg == ST_ADDR;
  endproperty
  a_read_op: assert property (p_read_op) else $error("read opcode not taken");

  property p_rts;
    @(posedge REF_CLK) disable iff (!RST_N)
    byte_evt && state_reg == ST_OPCODE && rx_byte[7:3] == OP_RTS_TOP && rx_byte[1]
      |=> mem_reg[TXB1_ADR][REQ_FLAG_BIT];
  endproperty
  a_rts: assert property (p_rts) else $error("request flag not set");

  property p_rts_zero;
    @(posedge REF_CLK) disable iff (!RST_N)
    byte_evt && state_reg == ST_OPCODE && rx_byte == {OP_RTS_TOP, 3'h0}
      |=> $stable(mem_reg[TXB0_ADR]) && $stable(mem_reg[TXB2_ADR]);
  endproperty
  a_rts_zero: assert property (p_rts_zero) else $error("empty request changed flags");

  property p_status;
    @(posedge REF_CLK) disable iff (!RST_N)
    byte_evt && state_reg == ST_OPCODE && rx_byte == OP_STATUS
      |=> drive_reg && tx_byte_reg == $past(status_byte) && state_reg == ST_STAT;
  endproperty
  a_status: assert property (p_status) else $error("status byte wrong");

  property p_read_inc;
    @(posedge REF_CLK) disable iff (!RST_N)
    byte_evt && state_reg == ST_RDATA |=> ptr_reg == $past(ptr_reg) + 8'h01;
  endproperty
  a_read_inc: assert property (p_read_inc) else $error("read pointer stuck");

  property p_write;
    @(posedge REF_CLK) disable iff (!RST_N)
    byte_evt && state_reg == ST_WDATA |=> mem_reg[$past(idx)] == $past(rx_byte);
  endproperty
  a_write: assert property (p_write) else $error("write byte lost");

  property p_modify;
    @(posedge REF_CLK) disable iff (!RST_N)
    byte_evt && state_reg == ST_MDATA |=> mem_reg[$past(idx)] ==
      (($past(mem_reg[idx]) & ~$past(mask_reg)) | ($past(rx_byte) & $past(mask_reg)));
  endproperty
  a_modify: assert property (p_modify) else $error("masked update wrong");

  property p_reset_cmd;
    @(posedge REF_CLK) disable iff (!RST_N)
    byte_evt && state_reg == ST_OPCODE && rx_byte == OP_RESET
      |=> mem_reg[TXB0_ADR] == 8'h00 && mem_reg[{3'h0, CTRL_LOW_ADR}] == CTRL_DEFAULT;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("reset command ineffective");

  property p_unknown;
    @(posedge REF_CLK) disable iff (!RST_N)
    byte_evt && state_reg == ST_OPCODE && rx_byte == 8'hff
      |=> !drive_reg && state_reg == ST_IGNORE;
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown opcode answered");

  c_read:   cover property (@(posedge REF_CLK) byte_evt && state_reg == ST_RDATA);
  c_modify: cover property (@(posedge REF_CLK) byte_evt && state_reg == ST_MDATA);
  c_status: cover property (@(posedge REF_CLK) byte_evt && state_reg == ST_STAT);

endmodule : can_spi_decoder

// ### common/can_spi_pkg.sv
package can_spi_pkg;

  // ---------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_READ    = 8'h03;
  localparam logic [7:0] OP_WRITE   = 8'h02;
  localparam logic [7:0] OP_MODIFY  = 8'h05;
  localparam logic [7:0] OP_STATUS  = 8'ha0;
  localparam logic [7:0] OP_RESET   = 8'hc0;
  localparam logic [4:0] OP_RTS_TOP = 5'h10;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int         REG_COUNT    = 128;
  localparam int         IDX_W        = 7;
  localparam logic [3:0] STAT_LOW_ADR = 4'he;
  localparam logic [3:0] CTRL_LOW_ADR = 4'hf;
  localparam logic [7:0] STAT_DEFAULT = 8'h80;
  localparam logic [7:0] CTRL_DEFAULT = 8'he7;
  localparam logic [6:0] INTF_ADR     = 7'h2c;
  localparam logic [6:0] TXB0_ADR     = 7'h30;
  localparam logic [6:0] TXB1_ADR     = 7'h40;
  localparam logic [6:0] TXB2_ADR     = 7'h50;
  localparam int         REQ_FLAG_BIT = 3;
  localparam int         RX0IF_BIT    = 0;
  localparam int         RX1IF_BIT    = 1;
  localparam int         TX0IF_BIT    = 2;
  localparam int         TX1IF_BIT    = 3;
  localparam int         TX2IF_BIT    = 4;
  localparam logic [2:0] BIT_LAST     = 3'h7;

endpackage : can_spi_pkg

// ### dv/spi_master.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Host side of the serial link, SCK idles between frames
// ------------------------------------------------------------
module spi_master (
  output logic      SCK,
  output logic      CS_N,
  output logic      SI,
  input  wire logic SO_OUT,
  input  wire logic SO_OE
);
  logic cpol    = 1'b0;
  logic oe_seen = 1'b0;

  initial begin
    SCK  = 1'b0;
    CS_N = 1'b1;
    SI   = 1'b0;
  end

  task automatic sel();
    SCK = cpol;
    #53;
    CS_N    = 1'b0;
    oe_seen = 1'b0;
    #80;
  endtask : sel

  // SI moves on falling edge, SO taken on rising
  task automatic xbyte(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < nbits; i++) begin
      SCK = 1'b0;
      SI  = tx[7-i];
      #80;
      SCK     = 1'b1;
      rx      = {rx[6:0], SO_OUT};
      oe_seen = oe_seen | SO_OE;
      #80;
    end
  endtask : xbyte

  // select held over whole frame; idle gap between frames
  task automatic desel();
    SCK = cpol;
    #40;
    CS_N = 1'b1;
    SI   = ~SI;
    #100;
  endtask : desel
endmodule : spi_master

// ### dv/testbench.sv
`timescale 1ns/1ps

module testbench;
  import can_spi_pkg::*;

  logic       REF_CLK = 1'b0;
  logic       RST_N   = 1'b0;
  logic       SCK;
  logic       CS_N;
  logic       SI;
  logic       SO_OUT;
  logic       SO_OE;
  logic [7:0] rbuf [8];
  int         miscompares = 0;
  int         checks_done = 0;
  int         cycles      = 0;

  always #5 REF_CLK = ~REF_CLK;

  can_spi_decoder can_spi_decoder_i (
    .REF_CLK (REF_CLK),
    .RST_N   (RST_N),
    .CE      (1'b1),
    .SCK     (SCK),
    .CS_N    (CS_N),
    .SI      (SI),
    .SO_OUT  (SO_OUT),
    .SO_OE   (SO_OE)
  );

  spi_master spi_master_i (
    .SCK    (SCK),
    .CS_N   (CS_N),
    .SI     (SI),
    .SO_OUT (SO_OUT),
    .SO_OE  (SO_OE)
  );

  // ------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic frame(input logic [7:0] q[$], input int nrd);
    logic [7:0] r;
    spi_master_i.sel();
    foreach (q[i]) spi_master_i.xbyte(q[i], 8, r);
    for (int i = 0; i < nrd; i++) begin
      spi_master_i.xbyte(8'h00, 8, r);
      rbuf[i] = r;
    end
    spi_master_i.desel();
  endtask : frame

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_defaults();
    frame('{OP_READ, 8'h0d}, 3);
    chk(rbuf[0], 8'h00);
    chk(rbuf[1], 8'h80);
    chk(rbuf[2], 8'he7);
    chk({7'h00, spi_master_i.oe_seen}, 8'h01);
  endtask : t_defaults

  task automatic t_write();
    logic [7:0] r;
    frame('{OP_WRITE, 8'h32, 8'h5a}, 0);
    spi_master_i.sel();
    spi_master_i.xbyte(OP_WRITE, 8, r);
    spi_master_i.xbyte(8'h31, 8, r);
    spi_master_i.xbyte(8'haa, 8, r);
    spi_master_i.xbyte(8'h55, 4, r);
    spi_master_i.desel();
    frame('{OP_READ, 8'h30}, 3);
    chk(rbuf[0], 8'h00);
    chk(rbuf[1], 8'haa);
    chk(rbuf[2], 8'h5a);
  endtask : t_write

  task automatic t_rts();
    logic [7:0] exp;
    for (int n = 0; n < 8; n++) begin
      frame('{OP_RESET}, 0);
      frame('{OP_WRITE, 8'h2c, 8'h15}, 0);
      frame('{{OP_RTS_TOP, 3'(n)}}, 0);
      exp = {1'b1, n[2], 1'b0, n[1], 1'b1, n[0], 1'b0, 1'b1};
      frame('{OP_STATUS}, 2);
      chk(rbuf[0], exp);
      chk(rbuf[1], exp);
      for (int k = 0; k < 3; k++) begin
        frame('{OP_READ, 8'(8'h30 + 16 * k)}, 1);
        chk(rbuf[0], {4'h0, n[k], 3'h0});
      end
    end
  endtask : t_rts

  task automatic t_modify();
    frame('{OP_WRITE, 8'h2c, 8'ha5}, 0);
    // target is a bit-modify capable register
    frame('{OP_MODIFY, 8'h2c, 8'h3c, 8'h0f}, 0);
    frame('{OP_READ, 8'h2c}, 1);
    chk(rbuf[0], 8'h8d);
    frame('{OP_RESET}, 0);
    frame('{OP_READ, 8'h2c}, 1);
    chk(rbuf[0], 8'h00);
    frame('{OP_READ, 8'h3e}, 2);
    chk(rbuf[0], 8'h80);
    chk(rbuf[1], 8'he7);
  endtask : t_modify

  task automatic t_mode11();
    spi_master_i.cpol = 1'b1;
    frame('{OP_WRITE, 8'h2c, 8'h15}, 0);
    frame('{OP_STATUS}, 1);
    chk(rbuf[0], 8'h89);
    frame('{OP_READ, 8'h2c}, 1);
    chk(rbuf[0], 8'h15);
    spi_master_i.cpol = 1'b0;
  endtask : t_mode11

  task automatic t_unknown();
    frame('{8'hff}, 1);
    chk({7'h00, spi_master_i.oe_seen}, 8'h00);
    frame('{OP_READ, 8'h2c}, 1);
    chk(rbuf[0], 8'h15);
  endtask : t_unknown

  task automatic t_pin_reset();
    frame('{OP_WRITE, 8'h2c, 8'ha5}, 0);
    @(posedge REF_CLK);
    #1 RST_N = 1'b0;
    repeat (2) @(posedge REF_CLK);
    #1 RST_N = 1'b1;
    repeat (4) @(posedge REF_CLK);
    frame('{OP_READ, 8'h2c}, 1);
    chk(rbuf[0], 8'h00);
    frame('{OP_READ, 8'h0e}, 1);
    chk(rbuf[0], 8'h80);
  endtask : t_pin_reset

  // ------------------------------------------------------------
  // Sequence and hang guard
  // ------------------------------------------------------------
  always @(posedge REF_CLK) begin
    cycles <= cycles + 1;
    if (cycles >= 60000) begin
      miscompares++;
      summarize();
    end
  end

  initial begin
    repeat (12) @(posedge REF_CLK);
    #1 RST_N = 1'b1;
    repeat (4) @(posedge REF_CLK);
    t_defaults();
    t_write();
    t_rts();
    t_modify();
    t_mode11();
    t_unknown();
    t_pin_reset();
    summarize();
  end
endmodule : testbench
